// ### tcpc_defs.svh
// Register indices, field positions, reset values and counts of the timer block
`ifndef TCPC_DEFS_SVH
`define TCPC_DEFS_SVH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TCPC_IDX_T1 8'h00
`define TCPC_IDX_T2 8'h01
`define TCPC_IDX_T3 8'h02
`define TCPC_IDX_PR1 8'h03
`define TCPC_IDX_PR2 8'h04
`define TCPC_IDX_CAP 8'h08
`define TCPC_IDX_STAT 8'h10
`define TCPC_IDX_MASK 8'h11
`define TCPC_IDX_PIN 8'h12
`define TCPC_IDX_MODE 8'h16
`define TCPC_IDX_RUN 8'h17
`define TCPC_IDX_UPC 8'h18
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TCPC_B_CS1 0
`define TCPC_B_CS2 1
`define TCPC_B_CS3 2
`define TCPC_B_PAIR 3
`define TCPC_B_RUN1 0
`define TCPC_B_RUN2 1
`define TCPC_B_RUN3 2
`define TCPC_B_CAPSEL 3
`define TCPC_B_PWM1 4
`define TCPC_B_PWM2 5
`define TCPC_B_PWM3 0
`define TCPC_ST_WIDE 0
`define TCPC_ST_FIRST 1
`define TCPC_ST_SECOND 2
`define TCPC_ST_CAP 3
// ----------------------------------------------------------------
// Reset values and prescale counts
// ----------------------------------------------------------------
`define TCPC_RST_MODE 8'h00
`define TCPC_RST_RUN 6'h00
`define TCPC_RST_UPC 5'h00
`define TCPC_RST_PER 8'hFF
`define TCPC_RST_PIN 6'h07
`define TCPC_PRE4_LAST 2'h3
`define TCPC_PRE16_LAST 4'hF
`endif

// ### tcpc_pkg.sv
// Types shared by the timer, capture and pulse pin control block
package tcpc_pkg;
    // Capture edge modes
    typedef enum logic [1:0] {
        TCPC_FALL = 2'b00,
        TCPC_RISE = 2'b01,
        TCPC_RISE4 = 2'b10,
        TCPC_RISE16 = 2'b11
    } tcpc_edge_t;
    typedef logic [15:0] tcpc_word_t;
endpackage : tcpc_pkg

// ### tcpc_cap_if.sv
// Signals between the block top and one capture channel
`timescale 1ns/100ps
interface tcpc_cap_if;
    tcpc_pkg::tcpc_edge_t mode; // Edge mode
    logic en; // Capture active (else period store)
    tcpc_pkg::tcpc_word_t timer; // Wide timer value
    logic rd_lo; // Low byte read
    logic rd_hi; // High byte read
    logic wr_lo; // Low byte write
    logic wr_hi; // High byte write
    logic [7:0] wdata; // Write byte
    tcpc_pkg::tcpc_word_t value; // Held value
    logic overrun; // Overrun status
    logic hit; // Qualifying edge pulse
    modport ctrl (output mode, en, timer, rd_lo, rd_hi, wr_lo, wr_hi,
                  wdata, input value, overrun, hit);
    modport chan (input mode, en, timer, rd_lo, rd_hi, wr_lo, wr_hi,
                  wdata, output value, overrun, hit);
endinterface : tcpc_cap_if

// ### tcpc_capture.sv
// One capture channel: pin synchroniser, edge prescaler, value and overrun
`timescale 1ns/100ps
`include "tcpc_defs.svh"
module tcpc_capture #(
    parameter int TW = 16
) (
    input wire logic clock, // System clock
    input wire logic rst, // Async reset, high
    input wire logic pin, // Raw capture pin
    tcpc_cap_if.chan cp // Channel link to top
);
    import tcpc_pkg::*;
    // ----------------------------------------------------------------
    // Checks and state
    // ----------------------------------------------------------------
    if (TW != 16) begin : g_chk
        $error("tcpc_capture: TW must be 16");
    end
    logic s1_q, s2_q, s3_q; // Pin synchroniser and history
    logic [3:0] pre_q, pre_d; // Rising edge prescaler
    logic [TW-1:0] val_q, val_d; // Captured or period value
    logic unread_q, unread_d; // Value not yet fully read
    logic ovr_q, ovr_d; // Overrun status
    logic lo_q, lo_d, hi_q, hi_d; // Bytes read so far
    logic rise, fall, hit, freed;
    // ----------------------------------------------------------------
    // Edge qualification
    // ----------------------------------------------------------------
    // Edges are seen only after two flops, so one pin edge is one hit
    assign rise = s2_q & ~s3_q;
    assign fall = ~s2_q & s3_q;
    always_comb begin
        case (cp.mode)
            TCPC_FALL: hit = fall;
            TCPC_RISE: hit = rise;
            TCPC_RISE4: hit = rise && (pre_q[1:0] == `TCPC_PRE4_LAST);
            TCPC_RISE16: hit = rise && (pre_q == `TCPC_PRE16_LAST);
            default: hit = 1'b0;
        endcase
    end
    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        pre_d = rise ? pre_q + 4'h1 : pre_q;
        val_d = val_q;
        unread_d = unread_q;
        ovr_d = ovr_q;
        lo_d = lo_q | cp.rd_lo;
        hi_d = hi_q | cp.rd_hi;
        freed = !unread_q || (lo_d && hi_d);
        // Both bytes read: release the value and the overrun
        if (unread_q && lo_d && hi_d) begin
            unread_d = 1'b0;
            ovr_d = 1'b0;
            lo_d = 1'b0;
            hi_d = 1'b0;
        end
        if (!cp.en) begin
            // Period store: software writes bytes, no capture
            if (cp.wr_lo) val_d[7:0] = cp.wdata;
            if (cp.wr_hi) val_d[15:8] = cp.wdata;
            unread_d = 1'b0;
            ovr_d = 1'b0;
        end else if (hit) begin
            if (freed) begin
                val_d = cp.timer;
                unread_d = 1'b1;
                lo_d = 1'b0;
                hi_d = 1'b0;
            end else begin
                ovr_d = 1'b1;
            end
        end
    end
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            pre_q <= 4'h0;
            val_q <= 16'hFFFF;
            unread_q <= 1'b0;
            ovr_q <= 1'b0;
            lo_q <= 1'b0;
            hi_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pre_q <= pre_d;
            val_q <= val_d;
            unread_q <= unread_d;
            ovr_q <= ovr_d;
            lo_q <= lo_d;
            hi_q <= hi_d;
        end
    end
    assign cp.value = val_q;
    assign cp.overrun = ovr_q;
    assign cp.hit = hit;
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    sequence full_read_s;
        unread_q && (lo_q || cp.rd_lo) && (hi_q || cp.rd_hi)
            && !(cp.en && hit);
    endsequence
    overrun_set_a: assert property (
        cp.en && hit && !freed |=> ovr_q && unread_q)
        else $error("overrun not flagged");
    keep_oldest_a: assert property (
        cp.en && unread_q && !freed |=> val_q == $past(val_q))
        else $error("held value overwritten");
    load_value_a: assert property (
        cp.en && hit && !unread_q |=> val_q == $past(cp.timer))
        else $error("capture value wrong");
    read_clear_a: assert property (
        full_read_s |=> !ovr_q && !unread_q)
        else $error("overrun not cleared by read");
    prescale_a: assert property (
        cp.mode == TCPC_RISE16 && pre_q != 4'hF |-> !hit)
        else $error("prescaled hit too early");
endmodule : tcpc_capture

// ### tcpc_top.sv
// Timer, capture and pulse pin control block with an AHB-Lite slave
//
// Function
// - Two-bit field picks capture edge and prescale
// - Pair bit joins two byte timers
// - Wide timer clocks from pin fall or internal
// - Second timer clocks from shared pin or internal
// - First timer clocks from shared pin or internal
// - Capture before full read sets overrun bit
// - After overrun keep old value, ignore captures
// - Capture loads current wide timer value
// - Pulse enable overrides pin direction bit
// - Mode bit picks capture one or period
// - Wide timer counts only while run set
// - First run bit gates pair or first timer
// - Wide flag on overflow or period rollover
// - Paired flag on combined period rollover
// - Each capture event sets its own flag
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/100ps
`include "tcpc_defs.svh"
module tcpc_top #(
    parameter int NUM_CAP = 4
) (
    input wire logic clock, // 20 MHz system clock
    input wire logic rst, // Async reset, high
    input wire logic hsel, // AHB select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size (word only)
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response
    input wire logic [3:0] cap_pin, // Capture pins
    input wire logic shared_timer_clock_pin, // Byte timers clock
    input wire logic wide_timer_clock_pin, // Wide timer clock
    input wire logic [2:0] pwm_wave, // Pulse waveforms
    output logic [2:0] pulse_pin_o, // Pin output level
    output logic [2:0] pulse_pin_oe_n, // Pin drive, low drives
    output logic irq // Interrupt level
);
    import tcpc_pkg::*;
    // ----------------------------------------------------------------
    // Checks and declarations
    // ----------------------------------------------------------------
    // Register map and status layout are fixed at four channels
    if (NUM_CAP != 4) begin : g_chk
        $error("tcpc_top: NUM_CAP must be 4");
    end
    tcpc_cap_if cif [NUM_CAP] (); // Channel links
    logic [7:0] mode_q, mode_d; // Edge modes, pair, clock selects
    logic [5:0] run_q, run_d; // Run bits, mode select, pulse enables
    logic [4:0] upc_q, upc_d; // Upper edge modes, third pulse enable
    logic [7:0] t1_q, t1_d, t2_q, t2_d; // Byte timers
    logic [7:0] pr1_q, pr1_d, pr2_q, pr2_d; // Byte periods
    tcpc_word_t t3_q, t3_d; // Wide timer
    logic [6:0] st_q, st_d, mask_q, mask_d; // Status and mask
    logic [5:0] pin_q, pin_d; // Direction [2:0], data [5:3]
    logic [1:0] ts1_q, ts2_q, ts3_q; // Timer pin sync
    logic wr_q; // Write data phase pending
    logic [7:0] wa_q; // Write index
    logic [31:0] hrdata_d;
    logic [2:0] pin_o_d, pin_oe_n_d;
    logic irq_d;
    logic [7:0] ra; // Address phase index
    logic rd_acc, f12, f3, pair, capsel, tick1, tick2, tick3;
    logic ev_wide, ev_first, ev_second;
    logic [NUM_CAP-1:0] hits, ovrs;
    tcpc_word_t capv [NUM_CAP];
    logic [1:0] cmode [NUM_CAP];
    // ----------------------------------------------------------------
    // Timer pin synchronisers
    // ----------------------------------------------------------------
    assign f12 = ts3_q[0] & ~ts2_q[0];
    assign f3 = ts3_q[1] & ~ts2_q[1];
    assign pair = mode_q[`TCPC_B_PAIR];
    assign capsel = run_q[`TCPC_B_CAPSEL];
    // Clock select: pin falling edge or every system clock
    assign tick1 = run_q[`TCPC_B_RUN1]
        && (mode_q[`TCPC_B_CS1] ? f12 : 1'b1);
    assign tick2 = run_q[`TCPC_B_RUN2]
        && (mode_q[`TCPC_B_CS2] ? f12 : 1'b1);
    assign tick3 = run_q[`TCPC_B_RUN3]
        && (mode_q[`TCPC_B_CS3] ? f3 : 1'b1);
    // ----------------------------------------------------------------
    // Capture channels
    // ----------------------------------------------------------------
    assign cmode[0] = mode_q[5:4];
    assign cmode[1] = mode_q[7:6];
    assign cmode[2] = upc_q[2:1];
    assign cmode[3] = upc_q[4:3];
    assign ra = haddr[9:2];
    assign rd_acc = hsel && htrans[1] && !hwrite && hready;
    for (genvar g = 0; g < NUM_CAP; g++) begin : g_cap
        assign cif[g].mode = tcpc_edge_t'(cmode[g]);
        // Only channel one doubles as the wide timer period
        assign cif[g].en = (g != 0) || capsel;
        assign cif[g].timer = t3_q;
        assign cif[g].rd_lo = rd_acc && ra == `TCPC_IDX_CAP + 8'(2 * g);
        assign cif[g].rd_hi = rd_acc
            && ra == `TCPC_IDX_CAP + 8'(2 * g + 1);
        assign cif[g].wr_lo = wr_q && wa_q == `TCPC_IDX_CAP + 8'(2 * g);
        assign cif[g].wr_hi = wr_q
            && wa_q == `TCPC_IDX_CAP + 8'(2 * g + 1);
        assign cif[g].wdata = hwdata[7:0];
        assign capv[g] = cif[g].value;
        assign ovrs[g] = cif[g].overrun;
        assign hits[g] = cif[g].hit && cif[g].en;
        tcpc_capture #(.TW(16)) u_cap (
            .clock(clock),
            .rst(rst),
            .pin(cap_pin[g]),
            .cp(cif[g])
        );
    end
    // ----------------------------------------------------------------
    // Timers and control registers, next values
    // ----------------------------------------------------------------
    always_comb begin
        t1_d = t1_q;
        t2_d = t2_q;
        t3_d = t3_q;
        ev_wide = 1'b0;
        ev_first = 1'b0;
        ev_second = 1'b0;
        if (pair) begin
            // Joined timer: upper byte takes the carry only if its run bit is set
            if (tick1) begin
                if ({t2_q, t1_q} == {pr2_q, pr1_q}) begin
                    t1_d = 8'h00;
                    t2_d = 8'h00;
                    ev_first = 1'b1;
                end else begin
                    t1_d = t1_q + 8'h01;
                    if (t1_q == 8'hFF && run_q[`TCPC_B_RUN2]) begin
                        t2_d = t2_q + 8'h01;
                    end
                end
            end
        end else begin
            if (tick1) begin
                if (t1_q == pr1_q) begin
                    t1_d = 8'h00;
                    ev_first = 1'b1;
                end else begin
                    t1_d = t1_q + 8'h01;
                end
            end
            if (tick2) begin
                if (t2_q == pr2_q) begin
                    t2_d = 8'h00;
                    ev_second = 1'b1;
                end else begin
                    t2_d = t2_q + 8'h01;
                end
            end
        end
        if (tick3) begin
            if (capsel) begin
                t3_d = t3_q + 16'h0001; // Free running
                ev_wide = (t3_q == 16'hFFFF);
            end else if (t3_q == capv[0]) begin
                t3_d = 16'h0000;
                ev_wide = 1'b1;
            end else begin
                t3_d = t3_q + 16'h0001;
            end
        end
        mode_d = mode_q;
        run_d = run_q;
        upc_d = upc_q;
        pr1_d = pr1_q;
        pr2_d = pr2_q;
        mask_d = mask_q;
        pin_d = pin_q;
        // Software writes win over counting in the same cycle
        if (wr_q) begin
            case (wa_q)
                `TCPC_IDX_T1: t1_d = hwdata[7:0];
                `TCPC_IDX_T2: t2_d = hwdata[7:0];
                `TCPC_IDX_T3: t3_d = hwdata[15:0];
                `TCPC_IDX_PR1: pr1_d = hwdata[7:0];
                `TCPC_IDX_PR2: pr2_d = hwdata[7:0];
                `TCPC_IDX_MASK: mask_d = hwdata[6:0];
                `TCPC_IDX_PIN: pin_d = hwdata[5:0];
                `TCPC_IDX_MODE: mode_d = hwdata[7:0];
                `TCPC_IDX_RUN: run_d = hwdata[5:0];
                `TCPC_IDX_UPC: upc_d = hwdata[4:0];
                default: mode_d = mode_q; // Unmapped: ignored
            endcase
        end
        // Read clears status; a new event in the same cycle survives
        st_d = st_q;
        if (rd_acc && ra == `TCPC_IDX_STAT) st_d = 7'h00;
        st_d = st_d | {hits, ev_second, ev_first, ev_wide};
    end
    // ----------------------------------------------------------------
    // Bus read data, pins and interrupt, next values
    // ----------------------------------------------------------------
    always_comb begin
        hrdata_d = 32'h0000_0000;
        if (rd_acc) begin
            case (ra)
                `TCPC_IDX_T1: hrdata_d[7:0] = t1_q;
                `TCPC_IDX_T2: hrdata_d[7:0] = t2_q;
                `TCPC_IDX_T3: hrdata_d[15:0] = t3_q;
                `TCPC_IDX_PR1: hrdata_d[7:0] = pr1_q;
                `TCPC_IDX_PR2: hrdata_d[7:0] = pr2_q;
                `TCPC_IDX_STAT: hrdata_d[6:0] = st_q;
                `TCPC_IDX_MASK: hrdata_d[6:0] = mask_q;
                `TCPC_IDX_PIN: hrdata_d[5:0] = pin_q;
                `TCPC_IDX_MODE: hrdata_d[7:0] = mode_q;
                `TCPC_IDX_RUN: hrdata_d[7:0] = {ovrs[1], ovrs[0], run_q};
                `TCPC_IDX_UPC: hrdata_d[7:0] = {1'b0, ovrs[3], ovrs[2], upc_q};
                default: begin
                    for (int i = 0; i < NUM_CAP; i++) begin
                        if (ra == `TCPC_IDX_CAP + 8'(2 * i))
                            hrdata_d[7:0] = capv[i][7:0];
                        if (ra == `TCPC_IDX_CAP + 8'(2 * i + 1))
                            hrdata_d[7:0] = capv[i][15:8];
                    end
                end
            endcase
        end
        // Enabled pulse output drives the pin, else direction bit rules
        pin_o_d[0] = run_q[`TCPC_B_PWM1] ? pwm_wave[0] : pin_q[3];
        pin_o_d[1] = run_q[`TCPC_B_PWM2] ? pwm_wave[1] : pin_q[4];
        pin_o_d[2] = upc_q[`TCPC_B_PWM3] ? pwm_wave[2] : pin_q[5];
        pin_oe_n_d[0] = run_q[`TCPC_B_PWM1] ? 1'b0 : pin_q[0];
        pin_oe_n_d[1] = run_q[`TCPC_B_PWM2] ? 1'b0 : pin_q[1];
        pin_oe_n_d[2] = upc_q[`TCPC_B_PWM3] ? 1'b0 : pin_q[2];
        irq_d = |(st_q & mask_q);
    end
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ts1_q <= 2'b00;
            ts2_q <= 2'b00;
            ts3_q <= 2'b00;
            mode_q <= `TCPC_RST_MODE;
            run_q <= `TCPC_RST_RUN;
            upc_q <= `TCPC_RST_UPC;
            t1_q <= 8'h00;
            t2_q <= 8'h00;
            t3_q <= 16'h0000;
            pr1_q <= `TCPC_RST_PER;
            pr2_q <= `TCPC_RST_PER;
            st_q <= 7'h00;
            mask_q <= 7'h00;
            pin_q <= `TCPC_RST_PIN;
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            pulse_pin_o <= 3'b000;
            pulse_pin_oe_n <= 3'b111;
            irq <= 1'b0;
        end else begin
            ts1_q <= {wide_timer_clock_pin, shared_timer_clock_pin};
            ts2_q <= ts1_q;
            ts3_q <= ts2_q;
            mode_q <= mode_d;
            run_q <= run_d;
            upc_q <= upc_d;
            t1_q <= t1_d;
            t2_q <= t2_d;
            t3_q <= t3_d;
            pr1_q <= pr1_d;
            pr2_q <= pr2_d;
            st_q <= st_d;
            mask_q <= mask_d;
            pin_q <= pin_d;
            wr_q <= hsel && htrans[1] && hwrite && hready;
            wa_q <= ra;
            hrdata <= hrdata_d;
            hreadyout <= 1'b1; // Zero wait states
            hresp <= 1'b0; // Always OKAY
            pulse_pin_o <= pin_o_d;
            pulse_pin_oe_n <= pin_oe_n_d;
            irq <= irq_d;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    pair_roll_a: assert property (
        pair && tick1 && {t2_q, t1_q} == {pr2_q, pr1_q} && !wr_q
        |=> t1_q == 8'h00 && t2_q == 8'h00 && st_q[`TCPC_ST_FIRST])
        else $error("paired rollover wrong");
    wide_period_a: assert property (
        !capsel && tick3 && t3_q == capv[0] && !wr_q
        |=> t3_q == 16'h0000 && st_q[`TCPC_ST_WIDE])
        else $error("wide period rollover wrong");
    wide_hold_a: assert property (
        !run_q[`TCPC_B_RUN3] && !wr_q |=> t3_q == $past(t3_q))
        else $error("wide timer moved while stopped");
    wide_pin_a: assert property (
        run_q[`TCPC_B_RUN3] && mode_q[`TCPC_B_CS3] && !f3 && !wr_q
        |=> $stable(t3_q))
        else $error("wide timer moved without pin edge");
    second_pin_a: assert property (
        !pair && mode_q[`TCPC_B_CS2] && !f12 && !wr_q |=> $stable(t2_q))
        else $error("second timer moved without pin edge");
    first_run_a: assert property (
        !run_q[`TCPC_B_RUN1] && pair && !wr_q |=> $stable({t2_q, t1_q}))
        else $error("joined timer moved while stopped");
    pin_drive_a: assert property (
        run_q[`TCPC_B_PWM1] |=> !pulse_pin_oe_n[0]
        && pulse_pin_o[0] == $past(pwm_wave[0]))
        else $error("pulse pin not driven");
    cap_flag_a: assert property (
        hits[2] |=> st_q[`TCPC_ST_CAP + 2] ##1 irq || !mask_q[5])
        else $error("capture flag not set");
    irq_level_a: assert property (
        |(st_q & mask_q) |=> irq)
        else $error("interrupt not raised");
endmodule : tcpc_top

// ### tcpc_pins.sv
// Model of the external capture pins and timer clock pins
`timescale 1ns/100ps
module tcpc_pins (
    input wire logic clock, // System clock
    output logic [3:0] cap_pin, // Capture pins, idle low
    output logic shared_clk, // Byte timer clock, idle high
    output logic wide_clk // Wide timer clock, idle high
);
    // Idle levels from time zero
    initial begin
        cap_pin = 4'h0;
        shared_clk = 1'b1;
        wide_clk = 1'b1;
    end
    // Held 4 cycles so the 2-flop synchroniser never misses it
    task pulse(input int sel);
        if (sel < 4) cap_pin[sel] <= 1'b1; // Rising capture edge
        else if (sel == 4) wide_clk <= 1'b0; // Falling edge
        else shared_clk <= 1'b0; // Falling shared edge
        repeat (4) @(posedge clock);
        cap_pin <= 4'h0;
        wide_clk <= 1'b1;
        shared_clk <= 1'b1;
        repeat (4) @(posedge clock);
    endtask : pulse
endmodule : tcpc_pins

// ### testbench.sv
// Self-checking testbench of the timer, capture and pulse pin block
`timescale 1ns/100ps
module testbench;
    logic clock, rst, hsel, hwrite, hreadyout, irq, shared_clk, wide_clk;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] pwm_wave, pulse_pin_o, pulse_pin_oe_n;
    logic [3:0] cap_pin;
    int errors = 0;
    int n_tests = 0;
    tcpc_top u_dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .cap_pin(cap_pin), .shared_timer_clock_pin(shared_clk),
        .wide_timer_clock_pin(wide_clk), .pwm_wave(pwm_wave),
        .pulse_pin_o(pulse_pin_o), .pulse_pin_oe_n(pulse_pin_oe_n),
        .irq(irq));
    tcpc_pins u_pins (.clock(clock), .cap_pin(cap_pin),
        .shared_clk(shared_clk), .wide_clk(wide_clk));
    // -------------------------------------------------------------
    // Shared tasks
    // -------------------------------------------------------------
    task results;
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One AHB single transfer; a hung hready ends the run
    task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        int k;
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'h2;
        hwrite <= w;
        for (int p = 0; p < 2; p++) begin
            k = 0;
            do begin
                @(posedge clock);
                k++;
            end while (hreadyout !== 1'b1 && k < 20);
            if (k >= 20) begin
                errors++;
                results;
            end
            if (p == 0) begin
                hsel <= 1'b0;
                htrans <= 2'h0;
                hwdata <= wd;
            end
        end
        rd = hrdata; // Old value at the edge ending the data phase
    endtask : bus
    task rdchk(input logic [7:0] idx, input logic [31:0] exp, input string nm);
        bus(1'b0, idx, 32'h0);
        chk(nm, rd, exp);
    endtask : rdchk
    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    task t_reset;
        rdchk(8'h16, 32'h0, "mode");
        rdchk(8'h17, 32'h0, "run");
        rdchk(8'h18, 32'h0, "upper");
        rdchk(8'h20, 32'h0, "unmapped");
        bus(1'b1, 8'h16, 32'h14); // Capture one rising, wide pin clock
        rdchk(8'h16, 32'h14, "mode");
    endtask : t_reset
    task t_wide;
        bus(1'b1, 8'h17, 32'h18); // Capture mode, wide timer stopped
        repeat (2) u_pins.pulse(4);
        rdchk(8'h02, 32'h0, "wide held");
        bus(1'b1, 8'h17, 32'h1C);
        repeat (3) u_pins.pulse(4);
        rdchk(8'h02, 32'h3, "wide count");
    endtask : t_wide
    task t_capture;
        bus(1'b0, 8'h08, 32'h0); // Release the reset value first
        bus(1'b0, 8'h09, 32'h0);
        bus(1'b1, 8'h11, 32'h08);
        u_pins.pulse(0);
        repeat (4) @(posedge clock);
        chk("irq", {31'h0, irq}, 32'h1);
        rdchk(8'h10, 32'h08, "status");
        repeat (3) @(posedge clock);
        chk("irq", {31'h0, irq}, 32'h0);
        rdchk(8'h08, 32'h3, "cap lo");
        u_pins.pulse(4);
        u_pins.pulse(0); // High byte still unread
        repeat (4) @(posedge clock);
        rdchk(8'h17, 32'h5C, "overrun");
        rdchk(8'h09, 32'h0, "cap hi");
        rdchk(8'h08, 32'h3, "cap kept");
        rdchk(8'h17, 32'h1C, "overrun");
        u_pins.pulse(0);
        repeat (4) @(posedge clock);
        rdchk(8'h08, 32'h4, "cap new");
    endtask : t_capture
    task t_pulse;
        pwm_wave <= 3'h5;
        repeat (3) @(posedge clock);
        chk("oe_n", {29'h0, pulse_pin_oe_n}, 32'h6);
        chk("pin out", {29'h0, pulse_pin_o}, 32'h1);
        bus(1'b1, 8'h18, 32'h01); // Third pulse output on
        repeat (2) @(posedge clock);
        chk("oe_n", {29'h0, pulse_pin_oe_n}, 32'h2);
        chk("pin out", {29'h0, pulse_pin_o}, 32'h5);
    endtask : t_pulse
    task t_edges;
        bus(1'b0, 8'h10, 32'h0); // Clear status
        u_pins.pulse(1);
        u_pins.pulse(2);
        u_pins.pulse(3);
        rdchk(8'h10, 32'h70, "fall caps");
        bus(1'b1, 8'h16, 32'hD4); // Capture two on every 16th rise
        repeat (14) u_pins.pulse(1);
        rdchk(8'h10, 32'h0, "pre16 early");
        u_pins.pulse(1);
        rdchk(8'h10, 32'h10, "pre16 hit");
    endtask : t_edges
    task t_timers;
        bus(1'b1, 8'h16, 32'h0B); // Paired, byte timers on shared pin
        bus(1'b1, 8'h00, 32'hFE);
        bus(1'b1, 8'h03, 32'h00);
        bus(1'b1, 8'h04, 32'h01); // Joined period 0100
        bus(1'b1, 8'h17, 32'h03); // Both run bits
        bus(1'b0, 8'h10, 32'h0);
        repeat (2) u_pins.pulse(5);
        rdchk(8'h01, 32'h1, "pair upper");
        u_pins.pulse(5);
        rdchk(8'h10, 32'h02, "pair flag");
        bus(1'b1, 8'h17, 32'h02); // Upper run only
        u_pins.pulse(5);
        rdchk(8'h00, 32'h0, "pair stopped");
        bus(1'b1, 8'h16, 32'h02); // Unpaired, second timer on pin
        u_pins.pulse(5);
        rdchk(8'h01, 32'h1, "second pin");
        bus(1'b1, 8'h02, 32'h0);
        bus(1'b1, 8'h17, 32'h04); // Wide timer, capture one as period
        bus(1'b0, 8'h10, 32'h0);
        repeat (8) @(posedge clock);
        rdchk(8'h10, 32'h01, "wide period");
    endtask : t_timers
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    initial begin
        rst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        pwm_wave = 3'h0;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset;
        t_wide;
        t_capture;
        t_pulse;
        t_edges;
        t_timers;
        results;
    end
endmodule : testbench
